// ---- frcct_pkg.sv ----
package frcct_pkg;
    // Channel counts
    localparam int NCAP = 4;
    localparam int NCMP = 8;
    localparam int NPAIR = 4;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] A_TMR_CTRL = 8'h00;
    localparam logic [7:0] A_TMR_COUNT = 8'h04;
    localparam logic [7:0] A_CAPCTL01 = 8'h08;
    localparam logic [7:0] A_CAPCTL23 = 8'h0c;
    localparam logic [7:0] A_CAPVAL0 = 8'h10;
    localparam logic [7:0] A_CAPVAL_END = 8'h1c;
    localparam logic [7:0] A_CMPVAL0 = 8'h20;
    localparam logic [7:0] A_CMPVAL_END = 8'h3c;
    localparam logic [7:0] A_OUTCTL0 = 8'h40;
    localparam logic [7:0] A_OUTCTL_END = 8'h4c;
    localparam logic [7:0] A_IRQ_STAT = 8'h50;
    localparam logic [7:0] A_IRQ_MASK = 8'h54;

    // Timer control fields
    localparam int TC_CLK_LSB = 0;
    localparam int TC_CLR_BIT = 2;
    localparam int TC_RUN_BIT = 3;
    localparam int TC_W = 4;
    localparam logic [3:0] TC_RST = 4'h0;

    // Prescaler masks: count clock = clk/1, /4, /16, /64
    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_MASK0 = 6'h00;
    localparam logic [5:0] PRE_MASK1 = 6'h03;
    localparam logic [5:0] PRE_MASK2 = 6'h0f;
    localparam logic [5:0] PRE_MASK3 = 6'h3f;

    // Capture control fields (per half register, two channels)
    localparam int CC_EDGE_LSB = 0;
    localparam int CC_EN_LSB = 4;
    localparam int CC_FLAG_LSB = 6;

    // Compare output control fields (per pair)
    localparam int OC_RUN_LSB = 0;
    localparam int OC_EN_LSB = 2;
    localparam int OC_FLAG_LSB = 4;
    localparam int OC_LEVEL_LSB = 8;
    localparam int OC_PAIR_BIT = 12;

    // Interrupt status layout
    localparam int ST_OVF = 0;
    localparam int ST_CAP_LSB = 1;
    localparam int ST_CMP_LSB = 5;
    localparam int ST_W = 13;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } frcct_edge_e;
endpackage

// ---- frcct_top.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: A 16-bit up counter is the shared time base, with control and status.
// RULE2: Software picks one of four count clocks divided from the system clock.
// RULE3: Counter wrapping past its maximum raises an overflow event with interrupt.
// RULE4: In clear mode the counter returns to zero on matching compare channel 0.
// RULE5: All capture and compare channels watch the same count value.
// RULE6: A selected capture edge copies the current count into that channel's value.
// RULE7: Each capture channel selects rising, falling or both edges.
// RULE8: A valid capture edge can request an interrupt.
// RULE9: Each capture channel has its own pin and independent edge detection.
// RULE10: Count equal to a compare value inverts that output and raises its flag.
// RULE11: Eight independent compare channels, each with own pin and flag.
// RULE12: In paired mode a match on either channel of the pair inverts the pin.
// RULE13: Software can preset each compare output level.
// RULE14: Events set sticky flags; interrupt only while flag and enable both set.
// RULE15: A compare channel acts only while its run bit is set; else it holds. Stopped odd pins still toggle on a paired even match; compare 0 still clears.
module frcct_top (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [frcct_pkg::ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Pins
    input wire logic [frcct_pkg::NCAP-1:0] i_cap_pin,
    output logic [frcct_pkg::NCMP-1:0] o_cmp_pin,
    output logic o_irq
);
    localparam int NCAP = frcct_pkg::NCAP;
    localparam int NCMP = frcct_pkg::NCMP;
    localparam int NPAIR = frcct_pkg::NPAIR;
    localparam int CW = frcct_pkg::CNT_W;
    localparam int SW = frcct_pkg::ST_W;

    logic [frcct_pkg::PRE_W-1:0] pre_r;
    logic [CW-1:0] count_r;
    logic [frcct_pkg::TC_W-1:0] tctl_r;
    logic [1:0] edge_r [NCAP];
    logic [CW-1:0] capval_r [NCAP];
    logic [CW-1:0] cmpval_r [NCMP];
    logic [NCMP-1:0] run_r;
    logic [NPAIR-1:0] pair_r;
    logic [NCMP-1:0] level_r;
    logic [SW-1:0] stat_r;
    logic [SW-1:0] mask_r;
    logic [NCAP-1:0] sync1_r;
    logic [NCAP-1:0] sync2_r;
    logic [NCAP-1:0] prev_r;
    logic dph_wr_r;
    logic [frcct_pkg::ADDR_W-1:0] dph_addr_r;

    logic [frcct_pkg::PRE_W-1:0] pre_mask;
    logic tick;
    logic clr_hit;
    logic ovf_ev;
    logic [NCAP-1:0] cap_ev;
    logic [NCMP-1:0] cmp_ev;
    logic [NCMP-1:0] toggle;
    logic wr_en;
    logic [SW-1:0] w1c;
    logic [SW-1:0] stat_set;
    logic [SW-1:0] stat_nxt;
    logic [NPAIR-1:0] oc_wr;
    logic [31:0] rd_nxt;

    // Count clock selection
    always_comb begin
        unique case (tctl_r[frcct_pkg::TC_CLK_LSB +: 2])
            2'b00: pre_mask = frcct_pkg::PRE_MASK0;
            2'b01: pre_mask = frcct_pkg::PRE_MASK1;
            2'b10: pre_mask = frcct_pkg::PRE_MASK2;
            default: pre_mask = frcct_pkg::PRE_MASK3;
        endcase
    end

    assign tick = i_ce && tctl_r[frcct_pkg::TC_RUN_BIT] && ((pre_r & pre_mask) == pre_mask); // [RULE2]
    assign clr_hit = tctl_r[frcct_pkg::TC_CLR_BIT] && (count_r == cmpval_r[0]);
    assign ovf_ev = tick && !clr_hit && (count_r == 16'hffff); // [RULE3]

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pre_r <= '0;
        end else if (i_ce) begin
            pre_r <= pre_r + 6'h01; // [RULE2]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_r <= '0;
        end else if (tick) begin
            if (clr_hit) begin
                count_r <= '0; // [RULE4]
            end else begin
                count_r <= count_r + 16'h0001; // [RULE1]
            end
        end
    end

    // Capture inputs: synchronise, detect edge, latch count
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else if (i_ce) begin
            sync1_r <= i_cap_pin;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    for (genvar c = 0; c < NCAP; c++) begin : g_cap
        logic rise;
        logic fall;
        assign rise = sync2_r[c] && !prev_r[c];
        assign fall = !sync2_r[c] && prev_r[c];
        assign cap_ev[c] = i_ce && ((rise && edge_r[c][0]) || (fall && edge_r[c][1])); // [RULE7] [RULE9]

        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                capval_r[c] <= '0;
            end else if (cap_ev[c]) begin
                capval_r[c] <= count_r; // [RULE5] [RULE6]
            end
        end
    end

    // Compare matches, gated by run bit
    for (genvar m = 0; m < NCMP; m++) begin : g_cmp
        assign cmp_ev[m] = tick && run_r[m] && (count_r == cmpval_r[m]); // [RULE10] [RULE15]
    end

    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        assign toggle[2*p] = cmp_ev[2*p]; // [RULE11]
        assign toggle[2*p+1] = cmp_ev[2*p+1] || (pair_r[p] && cmp_ev[2*p]); // [RULE12]
        assign oc_wr[p] = wr_en && (dph_addr_r == frcct_pkg::A_OUTCTL0 + 8'(4*p));
    end

    // Output latches: preset by write, else toggle on match
    for (genvar p = 0; p < NPAIR; p++) begin : g_lvl
        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                level_r[2*p +: 2] <= 2'b00;
            end else if (oc_wr[p]) begin
                level_r[2*p +: 2] <= i_hwdata[frcct_pkg::OC_LEVEL_LSB +: 2]; // [RULE13]
            end else if (i_ce) begin
                level_r[2*p +: 2] <= level_r[2*p +: 2] ^ toggle[2*p +: 2]; // [RULE10]
            end
        end
    end

    assign o_cmp_pin = level_r;

    // Interrupt status: set wins over write-one clear
    always_comb begin
        stat_set = '0;
        stat_set[frcct_pkg::ST_OVF] = ovf_ev;
        stat_set[frcct_pkg::ST_CAP_LSB +: NCAP] = cap_ev; // [RULE8]
        stat_set[frcct_pkg::ST_CMP_LSB +: NCMP] = cmp_ev;
        w1c = '0;
        if (wr_en && dph_addr_r == frcct_pkg::A_IRQ_STAT) begin
            w1c = i_hwdata[SW-1:0];
        end
        stat_nxt = (stat_r & ~w1c) | stat_set; // [RULE14]
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stat_r <= '0;
        end else if (i_ce) begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(stat_r & mask_r); // [RULE14]
        end
    end

    // AHB-Lite address phase capture
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= '0;
        end else if (i_ce) begin
            dph_wr_r <= i_hsel && i_htrans[1] && i_hwrite && i_hready;
            dph_addr_r <= {i_haddr[frcct_pkg::ADDR_W-1:2], 2'b00};
        end
    end

    assign wr_en = i_ce && dph_wr_r;

    // Software-written control registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tctl_r <= frcct_pkg::TC_RST;
            mask_r <= '0;
        end else if (wr_en) begin
            if (dph_addr_r == frcct_pkg::A_TMR_CTRL) begin
                tctl_r <= i_hwdata[frcct_pkg::TC_W-1:0];
            end
            if (dph_addr_r == frcct_pkg::A_IRQ_MASK) begin
                mask_r <= i_hwdata[SW-1:0];
            end
        end
    end

    for (genvar c = 0; c < NCAP; c++) begin : g_capctl
        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                edge_r[c] <= frcct_pkg::EDGE_OFF;
            end else if (wr_en && dph_addr_r == frcct_pkg::A_CAPCTL01 + 8'(4*(c/2))) begin
                edge_r[c] <= i_hwdata[frcct_pkg::CC_EDGE_LSB + 2*(c%2) +: 2]; // [RULE7]
            end
        end
    end

    for (genvar m = 0; m < NCMP; m++) begin : g_cmpval
        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                cmpval_r[m] <= '0;
            end else if (wr_en && dph_addr_r == frcct_pkg::A_CMPVAL0 + 8'(4*m)) begin
                cmpval_r[m] <= i_hwdata[CW-1:0];
            end
        end
    end

    for (genvar p = 0; p < NPAIR; p++) begin : g_ocs
        always_ff @(posedge i_clk_sys) begin
            if (i_rst) begin
                run_r[2*p +: 2] <= 2'b00;
                pair_r[p] <= 1'b0;
            end else if (oc_wr[p]) begin
                run_r[2*p +: 2] <= i_hwdata[frcct_pkg::OC_RUN_LSB +: 2]; // [RULE15]
                pair_r[p] <= i_hwdata[frcct_pkg::OC_PAIR_BIT]; // [RULE12]
            end
        end
    end

    // Read data selected in the address phase
    always_comb begin
        logic [1:0] ci;
        logic [2:0] mi;
        logic [1:0] pi;
        ci = i_haddr[3:2];
        mi = i_haddr[4:2];
        pi = i_haddr[3:2];
        rd_nxt = '0;
        if (i_haddr >= frcct_pkg::A_CAPVAL0 && i_haddr <= frcct_pkg::A_CAPVAL_END + 8'h3) begin
            rd_nxt[CW-1:0] = capval_r[ci];
        end else if (i_haddr >= frcct_pkg::A_CMPVAL0
                && i_haddr <= frcct_pkg::A_CMPVAL_END + 8'h3) begin
            rd_nxt[CW-1:0] = cmpval_r[mi];
        end else if (i_haddr >= frcct_pkg::A_OUTCTL0
                && i_haddr <= frcct_pkg::A_OUTCTL_END + 8'h3) begin
            rd_nxt[frcct_pkg::OC_RUN_LSB +: 2] = run_r[2*pi +: 2];
            rd_nxt[frcct_pkg::OC_EN_LSB +: 2] = mask_r[frcct_pkg::ST_CMP_LSB + 2*pi +: 2];
            rd_nxt[frcct_pkg::OC_FLAG_LSB +: 2] = stat_r[frcct_pkg::ST_CMP_LSB + 2*pi +: 2];
            rd_nxt[frcct_pkg::OC_LEVEL_LSB +: 2] = level_r[2*pi +: 2];
            rd_nxt[frcct_pkg::OC_PAIR_BIT] = pair_r[pi];
        end else begin
            unique case ({i_haddr[frcct_pkg::ADDR_W-1:2], 2'b00})
                frcct_pkg::A_TMR_CTRL: rd_nxt[frcct_pkg::TC_W-1:0] = tctl_r;
                frcct_pkg::A_TMR_COUNT: rd_nxt[CW-1:0] = count_r;
                frcct_pkg::A_CAPCTL01, frcct_pkg::A_CAPCTL23: begin
                    rd_nxt[frcct_pkg::CC_EDGE_LSB +: 2] = edge_r[{i_haddr[2], 1'b0}];
                    rd_nxt[frcct_pkg::CC_EDGE_LSB + 2 +: 2] = edge_r[{i_haddr[2], 1'b1}];
                    rd_nxt[frcct_pkg::CC_EN_LSB +: 2] =
                        mask_r[frcct_pkg::ST_CAP_LSB + 2*i_haddr[2] +: 2];
                    rd_nxt[frcct_pkg::CC_FLAG_LSB +: 2] =
                        stat_r[frcct_pkg::ST_CAP_LSB + 2*i_haddr[2] +: 2];
                end
                frcct_pkg::A_IRQ_STAT: rd_nxt[SW-1:0] = stat_r;
                frcct_pkg::A_IRQ_MASK: rd_nxt[SW-1:0] = mask_r;
                default: rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_hrdata <= '0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else if (i_ce) begin
            if (i_hsel && i_htrans[1] && !i_hwrite && i_hready) begin
                o_hrdata <= rd_nxt;
            end
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_cnt_inc;
        tick && !clr_hit |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not advance"); // [RULE1]

    property p_cnt_hold;
        !tick |=> $stable(count_r);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved off tick"); // [RULE2]

    property p_ovf;
        ovf_ev |=> stat_r[frcct_pkg::ST_OVF] && count_r == 16'h0000;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // [RULE3]

    property p_clr;
        tick && clr_hit |=> count_r == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("compare clear missed"); // [RULE4]

    property p_capture;
        cap_ev[0] |=> capval_r[0] == $past(count_r) && stat_r[frcct_pkg::ST_CAP_LSB];
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong"); // [RULE6]

    property p_cap_rise;
        i_ce && edge_r[1] == frcct_pkg::EDGE_RISE && !sync2_r[1] && prev_r[1] |-> !cap_ev[1];
    endproperty
    a_cap_rise: assert property (p_cap_rise) else $error("falling edge captured"); // [RULE7]

    property p_toggle;
        cmp_ev[0] && !oc_wr[0] |=> o_cmp_pin[0] != $past(o_cmp_pin[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("compare did not toggle"); // [RULE10]

    property p_pair;
        pair_r[0] && cmp_ev[0] && !cmp_ev[1] && !oc_wr[0]
            |=> o_cmp_pin[1] != $past(o_cmp_pin[1]);
    endproperty
    a_pair: assert property (p_pair) else $error("paired toggle missed"); // [RULE12]

    property p_irq;
        i_ce && |(stat_r & mask_r) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RULE14]

    property p_hold;
        !run_r[2] && !oc_wr[1] |=> o_cmp_pin[2] == $past(o_cmp_pin[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped channel toggled"); // [RULE15]

    property p_set_wins;
        |stat_set |=> (stat_r & $past(stat_set)) == $past(stat_set);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event flag lost"); // [RULE14]

    property p_preset;
        oc_wr[1] |=> o_cmp_pin[3:2] == $past(i_hwdata[frcct_pkg::OC_LEVEL_LSB +: 2]);
    endproperty
    a_preset: assert property (p_preset) else $error("preset level not applied"); // [RULE13]

    property p_cap_own;
        cap_ev[2] |-> sync2_r[2] != prev_r[2];
    endproperty
    a_cap_own: assert property (p_cap_own) else $error("capture without own pin edge"); // [RULE9]
endmodule

// ---- frcct_pin_model.sv ----
`timescale 1ns/100ps
module frcct_pin_model (
    // Clock and requested capture levels
    input wire logic i_clk_sys,
    input wire logic [frcct_pkg::NCAP-1:0] i_cap_lvl,
    // Pins
    output logic [frcct_pkg::NCAP-1:0] o_cap_pin,
    input wire logic [frcct_pkg::NCMP-1:0] i_cmp_pin,
    // Toggle count of each compare pin
    output int o_tog [8]
);
    logic [7:0] last = '0;
    int cnt [8] = '{default: 0};
    assign o_tog = cnt;
    // External source changes its level just after a clock edge
    always @(posedge i_clk_sys) begin
        o_cap_pin <= i_cap_lvl;
    end
    // Counted mid-cycle, where the registered pins have settled
    always @(negedge i_clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (i_cmp_pin[i] !== last[i]) cnt[i] <= cnt[i] + 1;
        end
        last <= i_cmp_pin;
    end
endmodule

// ---- freerun_capture_compare_timer_test.sv ----
`timescale 1ns/100ps
module freerun_capture_compare_timer_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [3:0] cap_lvl = 4'h0;
    logic [3:0] cap_pin;
    logic [7:0] cmp_pin;
    logic irq;
    int tog [8];
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int t_rd = 0;
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    frcct_top dut (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_cap_pin(cap_pin), .o_cmp_pin(cmp_pin), .o_irq(irq)
    );
    frcct_pin_model pins (.i_clk_sys(clk), .i_cap_lvl(cap_lvl), .o_cap_pin(cap_pin),
        .i_cmp_pin(cmp_pin), .o_tog(tog));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        t_rd = cyc;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask
    // Drives one capture pin and checks the flag it leaves, then clears it
    task automatic pin_step(input int ch, input logic v, input int f);
        logic [31:0] q;
        cap_lvl[ch] <= v;
        repeat (8) @(posedge clk);
        bus(1'b0, frcct_pkg::A_IRQ_STAT, 32'h0, q);
        chk("cap flag", f << (ch + 1), q);
        chk("cap irq", f, irq);
        bus(1'b1, frcct_pkg::A_IRQ_STAT, 32'h1e, q);
    endtask
    // Two full counter periods: each pin sees e matches, paired odd pins twice that
    task automatic tog_window(input int e, input logic [3:0] pm);
        int s [8];
        s = tog;
        repeat (512) @(posedge clk);
        for (int i = 0; i < 8; i++) chk("toggles", (pm[i / 2] && i % 2) ? 2 * e : e, tog[i] - s[i]);
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        logic [31:0] q;
        logic [31:0] c1;
        logic [3:0] pm;
        logic [1:0] lv [4];
        int d;
        int n;
        int r;
        void'($urandom(32'hdd13f5e3));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 'h60; a += 4) begin
            bus(1'b0, a[7:0], 32'h0, q);
            chk("reset read", 32'h0, q);
        end
        chk("reset pins", 32'h0, {irq, cmp_pin});
        $display("test reset done");
        bus(1'b1, frcct_pkg::A_TMR_CTRL, 32'h8, q);
        bus(1'b1, frcct_pkg::A_IRQ_MASK, 32'h1e, q);
        for (int ch = 0; ch < 4; ch++) begin
            for (int code = 0; code < 4; code++) begin
                bus(1'b1, ch < 2 ? frcct_pkg::A_CAPCTL01 : frcct_pkg::A_CAPCTL23,
                    code << (2 * (ch % 2)), q);
                bus(1'b0, frcct_pkg::A_TMR_COUNT, 32'h0, c1);
                pin_step(ch, 1'b1, code & 1);
                if (code & 1) begin
                    bus(1'b0, frcct_pkg::A_CAPVAL0 + 8'(4 * ch), 32'h0, q);
                    chk("cap value", 32'h1, 16'(q[15:0] - c1[15:0]) < 16'd16);
                end
                pin_step(ch, 1'b0, code >> 1);
            end
        end
        $display("test capture done");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, frcct_pkg::A_TMR_CTRL, 32'h8 | s, q);
            bus(1'b0, frcct_pkg::A_TMR_COUNT, 32'h0, c1);
            d = t_rd;
            repeat (253) @(posedge clk);
            bus(1'b0, frcct_pkg::A_TMR_COUNT, 32'h0, q);
            chk("count step", (t_rd - d) >> (2 * s), q - c1);
        end
        $display("test prescaler done");
        bus(1'b1, frcct_pkg::A_TMR_CTRL, 32'h8, q);
        bus(1'b1, frcct_pkg::A_IRQ_STAT, 32'h1fff, q);
        bus(1'b1, frcct_pkg::A_IRQ_MASK, 32'h1, q);
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        chk("overflow irq", 32'h1, irq);
        // Clear mode on; the count wraps at compare 0 once that is set below
        bus(1'b1, frcct_pkg::A_TMR_CTRL, 32'hc, q);
        bus(1'b1, frcct_pkg::A_IRQ_MASK, 32'h0, q);
        repeat (2) @(posedge clk);
        chk("masked irq", 32'h0, irq);
        bus(1'b0, frcct_pkg::A_IRQ_STAT, 32'h0, q);
        chk("overflow flag", 32'h1, q);
        bus(1'b1, frcct_pkg::A_IRQ_STAT, 32'h1, q);
        bus(1'b1, frcct_pkg::A_IRQ_MASK, 32'h1, q);
        repeat (2) @(posedge clk);
        chk("cleared irq", 32'h0, irq);
        $display("test overflow done");
        r = $urandom_range(31, 0);
        // Pair 0 always paired, pair 1 never, the rest drawn at random
        pm = {2'($urandom_range(3, 0)), 2'b01};
        bus(1'b1, frcct_pkg::A_CMPVAL0, 32'hff, q);
        for (int c = 1; c < 8; c++) bus(1'b1, frcct_pkg::A_CMPVAL0 + 8'(4 * c), 32 * c + r, q);
        for (int p = 0; p < 4; p++) begin
            lv[p] = 2'($urandom_range(3, 0));
            bus(1'b1, frcct_pkg::A_OUTCTL0 + 8'(4 * p), {lv[p], 8'h00}, q);
            bus(1'b0, frcct_pkg::A_OUTCTL0 + 8'(4 * p), 32'h0, q);
            chk("preset level", lv[p], q[9:8]);
        end
        chk("preset pins", {lv[3], lv[2], lv[1], lv[0]}, cmp_pin);
        tog_window(0, 4'h0);
        bus(1'b1, frcct_pkg::A_IRQ_STAT, 32'h1fff, q);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, frcct_pkg::A_OUTCTL0 + 8'(4 * p), {pm[p], 2'b00, lv[p], 8'h03}, q);
        end
        tog_window(2, pm);
        bus(1'b0, frcct_pkg::A_IRQ_STAT, 32'h0, q);
        chk("compare flags", 32'h1fe0, q);
        repeat (4) begin
            repeat ($urandom_range(99, 0)) @(posedge clk);
            bus(1'b0, frcct_pkg::A_TMR_COUNT, 32'h0, q);
            chk("cleared count", 32'h1, q < 256);
        end
        $display("test compare done");
        close_out();
    end
endmodule
